// ===== seoe_defs.vh
// constants for the event capture status logic
`ifndef SEOE_DEFS_VH
`define SEOE_DEFS_VH

`define SEOE_NIN          16
`define SEOE_DEPTH        160
`define SEOE_EW           37
`define SEOE_FAULT_W      32

`define SEOE_CLK_MHZ      100
`define SEOE_TICK_US      1000
`define SEOE_TICK_CYC     (`SEOE_CLK_MHZ * `SEOE_TICK_US)

`define SEOE_A_CTRL       8'h00
`define SEOE_A_CAPT       8'h04
`define SEOE_A_FILT       8'h08
`define SEOE_A_CHAT       8'h0C
`define SEOE_A_UPD        8'h10
`define SEOE_A_LEVEL      8'h14
`define SEOE_A_FAULT      8'h18
`define SEOE_A_PEND       8'h1C
`define SEOE_A_OVR        8'h20
`define SEOE_A_EVENT      8'h24
`define SEOE_A_TSTAMP     8'h28
`define SEOE_A_EVNUM      8'h2C
`define SEOE_A_RELEASE    8'h30
`define SEOE_A_QCNT       8'h34
`define SEOE_A_ISTAT      8'h38
`define SEOE_A_IMASK      8'h3C

`define SEOE_CTRL_HOLD    0
`define SEOE_CTRL_FLUSH   1
`define SEOE_EV_DIR       4
`define SEOE_EV_VALID     31

`define SEOE_CAPT_RST     32'hFFFFFFFF
`define SEOE_FILT_RST     8'h00
`define SEOE_CHAT_RST     24'h000000
`define SEOE_UPD_RST      16'h000A

`define SEOE_IRQ_EVENT    0
`define SEOE_IRQ_OVR      1
`define SEOE_IRQ_FAULT    2
`define SEOE_IRQ_UPD      3
`define SEOE_IRQ_W        4

`endif

// ===== seoe_sync.v
// two-flop synchroniser for the raw input pins
`default_nettype none
module seoe_sync #(
  parameter W = 16
) (
  input  wire         clk_i,
  input  wire         nrst_i,
  input  wire [W-1:0] d_i,
  output reg  [W-1:0] q_o
);
  reg [W-1:0] meta_r;

  always @(posedge clk_i) begin
    if (!nrst_i) begin
      meta_r <= {W{1'b0}};
      q_o    <= {W{1'b0}};
    end else begin
      meta_r <= d_i;
      q_o    <= meta_r;
    end
  end
endmodule
`default_nettype wire

// ===== seoe_evq.v
// 160-entry shared event queue
`include "seoe_defs.vh"
`default_nettype none
module seoe_evq (
  input  wire                   clk_i,
  input  wire                   nrst_i,
  input  wire                   flush_i,
  input  wire                   push_i,
  input  wire [`SEOE_EW-1:0]    wdata_i,
  input  wire                   pop_i,
  output wire [`SEOE_EW-1:0]    rdata_o,
  output reg  [7:0]             count_o,
  output wire                   full_o,
  output wire                   empty_o
);
  reg [`SEOE_EW-1:0] mem [0:`SEOE_DEPTH-1];
  reg [7:0]          wptr_r;
  reg [7:0]          rptr_r;

  function [7:0] seoe_inc;
    input [7:0] p;
    begin
      seoe_inc = (p == 8'd159) ? 8'h00 : p + 8'h01;
    end
  endfunction

  assign rdata_o = mem[rptr_r];
  assign full_o  = (count_o == 8'd160);
  assign empty_o = (count_o == 8'h00);

  always @(posedge clk_i) begin
    if (push_i) begin
      mem[wptr_r] <= wdata_i;
    end
  end

  // caller only pushes into a full queue together with a pop
  always @(posedge clk_i) begin
    if (!nrst_i || flush_i) begin
      wptr_r  <= 8'h00;
      rptr_r  <= 8'h00;
      count_o <= 8'h00;
    end else begin
      if (push_i) begin
        wptr_r <= seoe_inc(wptr_r);
      end
      if (pop_i && !empty_o) begin
        rptr_r <= seoe_inc(rptr_r);
      end
      if (push_i && !(pop_i && !empty_o)) begin
        count_o <= count_o + 8'h01;
      end else if (!push_i && pop_i && !empty_o) begin
        count_o <= count_o - 8'h01;
      end
    end
  end
endmodule
`default_nettype wire

// ===== seoe_top.v
// event capture status logic: flags, queue bookkeeping, registers
//
// Local design decisions: the placing of the registers and the strobed register port.
`include "seoe_defs.vh"
`default_nettype none
module seoe_top #(
  parameter TICK_CYCLES = `SEOE_TICK_CYC
) (
  input  wire                      clk_i,
  input  wire                      nrst_i,
  input  wire [`SEOE_NIN-1:0]      raw_in_i,
  input  wire                      comm_lost_i,
  input  wire [7:0]                addr_i,
  input  wire [31:0]               wdata_i,
  input  wire                      we_i,
  input  wire                      re_i,
  output reg  [31:0]               rdata_o,
  output wire [`SEOE_NIN-1:0]      input_level_o,
  output wire [`SEOE_FAULT_W-1:0]  fault_bits_o,
  output reg  [`SEOE_NIN-1:0]      pending_timestamp_bits_o,
  output reg  [`SEOE_NIN-1:0]      buffer_overrun_bits_o,
  output reg  [3:0]                event_input_index_o,
  output reg                       event_direction_o,
  output reg  [31:0]               event_time_o,
  output reg                       event_valid_o,
  output reg  [31:0]               running_event_count_o,
  output wire [7:0]                events_queued_o,
  output reg                       send_update_o,
  output wire                      irq_o
);
  localparam N = `SEOE_NIN;

  // configuration
  reg                 hold_events_option_r;
  reg  [31:0]         capt_r;
  reg  [7:0]          filt_ms_r;
  reg  [7:0]          chat_events_r;
  reg  [15:0]         chat_ms_r;
  reg  [15:0]         periodic_update_interval_r;
  reg  [`SEOE_IRQ_W-1:0] istat_r;
  reg  [`SEOE_IRQ_W-1:0] imask_r;

  // millisecond tick and clock-cycle time base
  reg  [31:0]         tick_cnt_r;
  reg                 tick_r;
  reg  [31:0]         system_time_base_r;
  reg  [15:0]         upd_cnt_r;
  reg                 upd_tick_r;

  wire [N-1:0]        sync_in;
  reg  [N-1:0]        level_r;
  reg  [N-1:0]        chatter_r;
  reg  [N-1:0]        req_r;
  reg  [N-1:0]        req_dir_r;
  wire [N-1:0]        flip;
  wire [N-1:0]        sel_hot;

  wire                wr_ctrl  = we_i && (addr_i == `SEOE_A_CTRL);
  wire                flush    = wr_ctrl && wdata_i[`SEOE_CTRL_FLUSH];
  wire                wr_rel   = we_i && (addr_i == `SEOE_A_RELEASE);

  seoe_sync #(
    .W (N)
  ) u_sync (
    .clk_i  (clk_i),
    .nrst_i (nrst_i),
    .d_i    (raw_in_i),
    .q_o    (sync_in)
  );

  always @(posedge clk_i) begin
    if (!nrst_i) begin
      tick_cnt_r         <= 32'h00000000;
      tick_r             <= 1'b0;
      system_time_base_r <= 32'h00000000;
    end else begin
      system_time_base_r <= system_time_base_r + 32'h00000001;
      if (tick_cnt_r == TICK_CYCLES - 1) begin
        tick_cnt_r <= 32'h00000000;
        tick_r     <= 1'b1;
      end else begin
        tick_cnt_r <= tick_cnt_r + 32'h00000001;
        tick_r     <= 1'b0;
      end
    end
  end

  // periodic update interval in ms; zero stops the periodic update
  always @(posedge clk_i) begin
    if (!nrst_i) begin
      upd_cnt_r  <= 16'h0000;
      upd_tick_r <= 1'b0;
    end else begin
      upd_tick_r <= 1'b0;
      if (tick_r && (periodic_update_interval_r != 16'h0000)) begin
        if (upd_cnt_r + 16'h0001 >= periodic_update_interval_r) begin
          upd_cnt_r  <= 16'h0000;
          upd_tick_r <= 1'b1;
        end else begin
          upd_cnt_r <= upd_cnt_r + 16'h0001;
        end
      end
    end
  end

  // per-input filter and chatter watch
  genvar gi;
  generate
    for (gi = 0; gi < N; gi = gi + 1) begin : g_in
      reg [7:0]  flt_cnt_r;
      reg [7:0]  ev_cnt_r;
      reg [15:0] quiet_r;

      assign flip[gi] = (sync_in[gi] != level_r[gi]) &&
                        ((filt_ms_r == 8'h00) || (tick_r && flt_cnt_r + 8'h01 >= filt_ms_r));

      always @(posedge clk_i) begin
        if (!nrst_i) begin
          flt_cnt_r <= 8'h00;
          level_r[gi] <= 1'b0;
        end else if (sync_in[gi] == level_r[gi]) begin
          flt_cnt_r <= 8'h00;
        end else if (flip[gi]) begin
          level_r[gi] <= sync_in[gi];
          flt_cnt_r   <= 8'h00;
        end else if (tick_r) begin
          flt_cnt_r <= flt_cnt_r + 8'h01;
        end
      end

      // burst counter restarts once the line has been quiet a full window
      always @(posedge clk_i) begin
        if (!nrst_i) begin
          ev_cnt_r      <= 8'h00;
          quiet_r       <= 16'h0000;
          chatter_r[gi] <= 1'b0;
        end else if (chat_events_r == 8'h00) begin
          ev_cnt_r      <= 8'h00;
          chatter_r[gi] <= 1'b0;
        end else if (flip[gi]) begin
          quiet_r <= 16'h0000;
          if (quiet_r >= chat_ms_r) begin
            ev_cnt_r <= 8'h01;
          end else if (ev_cnt_r != 8'hFF) begin
            ev_cnt_r <= ev_cnt_r + 8'h01;
          end
          if (quiet_r < chat_ms_r && ev_cnt_r >= chat_events_r) begin
            chatter_r[gi] <= 1'b1;
          end
        end else if (tick_r && quiet_r != 16'hFFFF) begin
          quiet_r <= quiet_r + 16'h0001;
          if (quiet_r + 16'h0001 >= chat_ms_r) begin
            chatter_r[gi] <= 1'b0;
            ev_cnt_r      <= 8'h00;
          end
        end
      end

      // capture request waits here until the arbiter serves it
      always @(posedge clk_i) begin
        if (!nrst_i || flush) begin
          req_r[gi]     <= 1'b0;
          req_dir_r[gi] <= 1'b0;
        end else if (flip[gi] && !chatter_r[gi] &&
                     capt_r[sync_in[gi] ? gi : gi + 16]) begin
          req_r[gi]     <= 1'b1;
          req_dir_r[gi] <= sync_in[gi];
        end else if (sel_hot[gi]) begin
          req_r[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  assign input_level_o = level_r;
  assign fault_bits_o  = {{16{comm_lost_i}}, chatter_r | {N{comm_lost_i}}};

  // lowest index served first; a request waits at most 16 cycles,
  // which adds to the synchroniser and request delay between transition and stamp
  function [4:0] seoe_pick;
    input [N-1:0] r;
    integer k;
    begin
      seoe_pick = 5'h10;
      for (k = N - 1; k >= 0; k = k - 1) begin
        if (r[k]) begin
          seoe_pick = k[4:0];
        end
      end
    end
  endfunction

  wire [4:0]   sel     = seoe_pick(req_r);
  wire         sel_v   = !sel[4];
  wire [3:0]   sel_idx = sel[3:0];
  assign sel_hot = sel_v ? ({{(N-1){1'b0}}, 1'b1} << sel_idx) : {N{1'b0}};

  // queue control
  wire [`SEOE_EW-1:0] q_head;
  wire [7:0]          q_cnt;
  wire                q_full;
  wire                q_empty;
  wire                rel_pop  = wr_rel && event_valid_o && (wdata_i == running_event_count_o);
  wire                full_eff = q_full && !rel_pop;
  wire                push     = sel_v && !flush && !(full_eff && hold_events_option_r);
  wire                ovw_pop  = push && full_eff;
  wire                dropped  = sel_v && !flush && full_eff;
  wire                pop      = rel_pop || ovw_pop;

  seoe_evq u_q (
    .clk_i   (clk_i),
    .nrst_i  (nrst_i),
    .flush_i (flush),
    .push_i  (push),
    .wdata_i ({system_time_base_r, req_dir_r[sel_idx], sel_idx}),
    .pop_i   (pop),
    .rdata_o (q_head),
    .count_o (q_cnt),
    .full_o  (q_full),
    .empty_o (q_empty)
  );

  assign events_queued_o = q_cnt;

  // head presentation and event numbering
  always @(posedge clk_i) begin
    if (!nrst_i) begin
      event_valid_o         <= 1'b0;
      event_input_index_o   <= 4'h0;
      event_direction_o     <= 1'b0;
      event_time_o          <= 32'h00000000;
      running_event_count_o <= 32'h00000000;
    end else if (flush || pop) begin
      event_valid_o <= 1'b0;
    end else if (!event_valid_o && !q_empty) begin
      event_valid_o         <= 1'b1;
      event_input_index_o   <= q_head[3:0];
      event_direction_o     <= q_head[`SEOE_EV_DIR];
      event_time_o          <= q_head[`SEOE_EW-1:5];
      running_event_count_o <= running_event_count_o + 32'h00000001;
    end
  end

  // per-input pending and overrun flags
  wire [N-1:0] pend_ack = (we_i && addr_i == `SEOE_A_PEND) ? wdata_i[N-1:0] : {N{1'b0}};
  wire [N-1:0] pend_set = push ? sel_hot : {N{1'b0}};

  always @(posedge clk_i) begin
    if (!nrst_i) begin
      pending_timestamp_bits_o <= {N{1'b0}};
      buffer_overrun_bits_o    <= {N{1'b0}};
      send_update_o            <= 1'b0;
    end else begin
      if (flush) begin
        pending_timestamp_bits_o <= {N{1'b0}};
      end else begin
        pending_timestamp_bits_o <= (pending_timestamp_bits_o & ~pend_ack) | pend_set;
      end
      if (dropped) begin
        buffer_overrun_bits_o <= buffer_overrun_bits_o | sel_hot;
      end
      send_update_o <= push || upd_tick_r;
    end
  end

  // interrupt status, set wins over write-one-to-clear
  reg  [N-1:0]           chat_d_r;
  wire [`SEOE_IRQ_W-1:0] ev_set = {upd_tick_r, |(chatter_r & ~chat_d_r), dropped, push};
  wire [`SEOE_IRQ_W-1:0] ev_clr = (we_i && addr_i == `SEOE_A_ISTAT) ? wdata_i[`SEOE_IRQ_W-1:0]
                                                                    : {`SEOE_IRQ_W{1'b0}};

  always @(posedge clk_i) begin
    if (!nrst_i) begin
      istat_r  <= {`SEOE_IRQ_W{1'b0}};
      chat_d_r <= {N{1'b0}};
    end else begin
      istat_r  <= (istat_r & ~ev_clr) | ev_set;
      chat_d_r <= chatter_r;
    end
  end

  assign irq_o = |(istat_r & imask_r);

  // register writes
  always @(posedge clk_i) begin
    if (!nrst_i) begin
      hold_events_option_r       <= 1'b0;
      capt_r                     <= `SEOE_CAPT_RST;
      filt_ms_r                  <= `SEOE_FILT_RST;
      {chat_ms_r, chat_events_r} <= `SEOE_CHAT_RST;
      periodic_update_interval_r <= `SEOE_UPD_RST;
      imask_r                    <= {`SEOE_IRQ_W{1'b0}};
    end else if (we_i) begin
      case (addr_i)
        `SEOE_A_CTRL:  hold_events_option_r <= wdata_i[`SEOE_CTRL_HOLD];
        `SEOE_A_CAPT:  capt_r <= wdata_i;
        `SEOE_A_FILT:  filt_ms_r <= wdata_i[7:0];
        `SEOE_A_CHAT: begin
          chat_events_r <= wdata_i[7:0];
          chat_ms_r     <= wdata_i[23:8];
        end
        `SEOE_A_UPD:   periodic_update_interval_r <= wdata_i[15:0];
        `SEOE_A_IMASK: imask_r <= wdata_i[`SEOE_IRQ_W-1:0];
        default: begin
        end
      endcase
    end
  end

  // read data one cycle after the strobe; unmapped reads zero
  always @(posedge clk_i) begin
    if (!nrst_i) begin
      rdata_o <= 32'h00000000;
    end else if (re_i) begin
      case (addr_i)
        `SEOE_A_CTRL:   rdata_o <= {31'h00000000, hold_events_option_r};
        `SEOE_A_CAPT:   rdata_o <= capt_r;
        `SEOE_A_FILT:   rdata_o <= {24'h000000, filt_ms_r};
        `SEOE_A_CHAT:   rdata_o <= {8'h00, chat_ms_r, chat_events_r};
        `SEOE_A_UPD:    rdata_o <= {16'h0000, periodic_update_interval_r};
        `SEOE_A_LEVEL:  rdata_o <= {16'h0000, level_r};
        `SEOE_A_FAULT:  rdata_o <= fault_bits_o;
        `SEOE_A_PEND:   rdata_o <= {16'h0000, pending_timestamp_bits_o};
        `SEOE_A_OVR:    rdata_o <= {16'h0000, buffer_overrun_bits_o};
        `SEOE_A_EVENT:  rdata_o <= {event_valid_o, 26'h0000000, event_direction_o, event_input_index_o};
        `SEOE_A_TSTAMP: rdata_o <= event_time_o;
        `SEOE_A_EVNUM:  rdata_o <= running_event_count_o;
        `SEOE_A_QCNT:   rdata_o <= {24'h000000, q_cnt};
        `SEOE_A_ISTAT:  rdata_o <= {28'h0000000, istat_r};
        `SEOE_A_IMASK:  rdata_o <= {28'h0000000, imask_r};
        default:        rdata_o <= 32'h00000000;
      endcase
    end
  end
endmodule
`default_nettype wire

// ===== seoe_top_properties.sv
// concurrent checks on the event capture status ports
`include "seoe_defs.vh"
`default_nettype none
module seoe_top_props #(
  parameter TICK_CYCLES = 10
) (
  input wire logic        clk_i,
  input wire logic        nrst_i,
  input wire logic        comm_lost_i,
  input wire logic [7:0]  addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic        we_i,
  input wire logic [31:0] fault_bits_o,
  input wire logic [15:0] pending_timestamp_bits_o,
  input wire logic [15:0] buffer_overrun_bits_o,
  input wire logic        event_valid_o,
  input wire logic [31:0] running_event_count_o,
  input wire logic [7:0]  events_queued_o,
  input wire logic        send_update_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  logic [31:0] gap_r;
  wire rel_wr = we_i && addr_i == `SEOE_A_RELEASE && event_valid_o;
  // cycles since the last update pulse; default interval is 10 ticks
  always @(posedge clk_i) begin
    if (!nrst_i || send_update_o)
      gap_r <= 32'h0;
    else
      gap_r <= gap_r + 32'h1;
  end
  a_comm_all_set: assert property (comm_lost_i |-> fault_bits_o == 32'hFFFFFFFF)
    else $error("fault word not all ones on comm loss");
  a_fault_upper_idle: assert property (!comm_lost_i |-> fault_bits_o[31:16] == 16'h0000)
    else $error("upper fault bits stay set without comm loss");
  a_pend_clear_src: assert property (|($past(pending_timestamp_bits_o) & ~pending_timestamp_bits_o)
    |-> $past(we_i) && ($past(addr_i) == `SEOE_A_PEND || $past(addr_i) == `SEOE_A_CTRL))
    else $error("pending bit cleared without acknowledge");
  a_ovr_sticky: assert property (($past(buffer_overrun_bits_o) & ~buffer_overrun_bits_o) == 16'h0000)
    else $error("overrun bit fell without reset");
  a_count_step: assert property ((running_event_count_o != $past(running_event_count_o))
    |-> running_event_count_o == $past(running_event_count_o) + 32'h1)
    else $error("event count did not step by one");
  a_release_ok: assert property (rel_wr && wdata_i == running_event_count_o |=> !event_valid_o)
    else $error("matching release left event presented");
  a_release_bad: assert property (rel_wr && wdata_i != running_event_count_o |=> event_valid_o)
    else $error("wrong release dropped the event");
  a_queue_cap: assert property (events_queued_o <= 8'hA0)
    else $error("queue holds more than its depth");
  a_push_update: assert property (events_queued_o > $past(events_queued_o) |-> send_update_o)
    else $error("push without update pulse");
  a_update_gap: assert property (gap_r < 32'(11 * TICK_CYCLES))
    else $error("periodic update missing");
endmodule
bind seoe_top seoe_top_props #(.TICK_CYCLES(TICK_CYCLES)) u_props (
  .clk_i(clk_i), .nrst_i(nrst_i), .comm_lost_i(comm_lost_i), .addr_i(addr_i), .wdata_i(wdata_i),
  .we_i(we_i), .fault_bits_o(fault_bits_o), .pending_timestamp_bits_o(pending_timestamp_bits_o),
  .buffer_overrun_bits_o(buffer_overrun_bits_o), .event_valid_o(event_valid_o),
  .running_event_count_o(running_event_count_o), .events_queued_o(events_queued_o),
  .send_update_o(send_update_o));
`default_nettype wire

// ===== seoe_ctrl_model.sv
// owner controller model: releases each presented event
`include "seoe_defs.vh"
`default_nettype none
module seoe_ctrl_model (
  input  wire logic        clk_i,
  input  wire logic        nrst_i,
  input  wire logic        en_i,
  input  wire logic [3:0]  dly_i,
  input  wire logic        event_valid_i,
  input  wire logic [31:0] count_i,
  output logic             we_o,
  output logic [7:0]       addr_o,
  output logic [31:0]      wdata_o,
  output logic [7:0]       n_rel_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0]  wait_r;
  logic [31:0] last_r = 32'h0;
  assign addr_o = `SEOE_A_RELEASE;
  // idle data inverted so a stale word never reads as a release
  assign wdata_o = we_o ? last_r : ~last_r;
  always @(posedge clk_i) begin
    if (!nrst_i || !en_i || !event_valid_i || we_o) begin
      we_o <= 1'b0;
      wait_r <= 4'h0;
    end else if (wait_r >= dly_i) begin
      we_o <= 1'b1;
      last_r <= count_i;
    end else
      wait_r <= wait_r + 4'h1;
    if (!nrst_i)
      n_rel_o <= 8'h00;
    else if (we_o)
      n_rel_o <= n_rel_o + 8'h01;
  end
endmodule
`default_nettype wire

// ===== seoe_top_bench.sv
// self-checking bench for the event capture status logic
`include "seoe_defs.vh"
`default_nettype none
module seoe_top_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_i = 1'b0;
  logic        nrst_i = 1'b0;
  logic [15:0] raw_r = 16'h0000;
  logic        comm_r = 1'b0;
  logic [7:0]  addr_r = 8'h00;
  logic [31:0] wdata_r = 32'h0;
  logic        we_r = 1'b0;
  logic        re_r = 1'b0;
  logic        m_en = 1'b0;
  logic [3:0]  m_dly = 4'h0;
  logic        m_we;
  logic [7:0]  m_addr;
  logic [31:0] m_wdata;
  logic [7:0]  m_nrel;
  logic [31:0] rdata, fault, etim, cnt, d;
  logic [15:0] lvl, pend, ovr;
  logic [7:0]  qd;
  logic [3:0]  idx;
  logic        dir, valid, upd, irq;
  int          n_fail = 0;
  int          num_checks = 0;
  int          cyc = 0;
  int          i;
  seoe_top #(.TICK_CYCLES(10)) u_dut (
    .clk_i(clk_i), .nrst_i(nrst_i), .raw_in_i(raw_r), .comm_lost_i(comm_r),
    .addr_i(m_we ? m_addr : addr_r), .wdata_i(m_we ? m_wdata : wdata_r), .we_i(we_r | m_we),
    .re_i(re_r), .rdata_o(rdata), .input_level_o(lvl), .fault_bits_o(fault),
    .pending_timestamp_bits_o(pend), .buffer_overrun_bits_o(ovr), .event_input_index_o(idx),
    .event_direction_o(dir), .event_time_o(etim), .event_valid_o(valid),
    .running_event_count_o(cnt), .events_queued_o(qd), .send_update_o(upd), .irq_o(irq));
  seoe_ctrl_model u_ctrl (
    .clk_i(clk_i), .nrst_i(nrst_i), .en_i(m_en), .dly_i(m_dly), .event_valid_i(valid),
    .count_i(cnt), .we_o(m_we), .addr_o(m_addr), .wdata_o(m_wdata), .n_rel_o(m_nrel));
  initial begin
    forever #5 clk_i = ~clk_i;
  end
  task automatic final_report;
    $display("checks %0d failures %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      n_fail++;
      $display("ERROR %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic cyc_n(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_i);
    addr_r <= a;
    wdata_r <= v;
    we_r <= 1'b1;
    @(posedge clk_i);
    we_r <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk_i);
    addr_r <= a;
    re_r <= 1'b1;
    @(posedge clk_i);
    re_r <= 1'b0;
    #1 v = rdata;
  endtask
  // synchroniser, filter stage and push all fit inside six cycles
  task automatic flip(input int b);
    @(posedge clk_i);
    raw_r[b] <= ~raw_r[b];
    cyc_n(6);
  endtask
  task automatic wait_valid(input logic want);
    int k;
    for (k = 0; k < 200 && valid !== want; k++)
      cyc_n(1);
    chk(32'(valid), 32'(want));
  endtask
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      n_fail++;
      final_report;
    end
  end
  initial begin
    repeat (5) @(posedge clk_i);
    nrst_i <= 1'b1;
    cyc_n(1);
    chk(32'(cnt), 32'h0);
    rd(`SEOE_A_CAPT, d);
    chk(d, `SEOE_CAPT_RST);
    rd(8'hFC, d);
    chk(d, 32'h0);
    @(posedge clk_i);
    comm_r <= 1'b1;
    cyc_n(1);
    chk(fault, 32'hFFFFFFFF);
    @(posedge clk_i);
    comm_r <= 1'b0;
    cyc_n(1);
    chk(fault, 32'h0);
    wr(`SEOE_A_IMASK, 32'h1);
    flip(3);
    wait_valid(1'b1);
    chk(32'(idx), 32'h3);
    chk(32'(dir), 32'h1);
    chk(cnt, 32'h1);
    chk(32'(lvl), 32'h8);
    chk(32'(pend), 32'h8);
    chk(32'(irq), 32'h1);
    wr(`SEOE_A_ISTAT, 32'h1);
    chk(32'(irq), 32'h0);
    wr(`SEOE_A_RELEASE, 32'h0);
    chk(32'(valid), 32'h1);
    wr(`SEOE_A_RELEASE, 32'h1);
    chk(32'(valid), 32'h0);
    chk(32'(pend), 32'h8);
    wr(`SEOE_A_PEND, 32'h8);
    chk(32'(pend), 32'h0);
    wr(`SEOE_A_IMASK, 32'h0);
    // two inputs rise together; the controller model releases
    @(posedge clk_i);
    m_en <= 1'b1;
    raw_r <= 16'h002C;
    wait_valid(1'b1);
    chk(32'(idx), 32'h2);
    chk(cnt, 32'h2);
    d = etim;
    wait_valid(1'b0);
    wait_valid(1'b1);
    chk(32'(idx), 32'h5);
    chk(etim, d + 32'h1);
    chk(cnt, 32'h3);
    wait_valid(1'b0);
    @(posedge clk_i);
    m_dly <= 4'h5;
    raw_r <= 16'h000C;
    wait_valid(1'b1);
    chk(32'(dir), 32'h0);
    wait_valid(1'b0);
    chk(32'(m_nrel), 32'h3);
    chk(32'(lvl), 32'hC);
    chk(32'(pend), 32'h24);
    m_en <= 1'b0;
    rd(`SEOE_A_ISTAT, d);
    chk(d & 32'h1, 32'h1);
    chk(32'(irq), 32'h0);
    wr(`SEOE_A_CTRL, 32'h3);
    chk(32'(pend), 32'h0);
    for (i = 0; i < 400 && qd !== 8'hA0; i++)
      flip(0);
    chk(32'(ovr), 32'h0);
    flip(1);
    chk(32'(ovr), 32'h2);
    chk(32'(qd), 32'hA0);
    chk(cnt, 32'h5);
    wr(`SEOE_A_CTRL, 32'h0);
    flip(2);
    chk(32'(ovr), 32'h6);
    chk(32'(qd), 32'hA0);
    chk(cnt, 32'h6);
    wr(`SEOE_A_CTRL, 32'h2);
    chk(32'(ovr), 32'h6);
    @(posedge clk_i);
    nrst_i <= 1'b0;
    repeat (5) @(posedge clk_i);
    nrst_i <= 1'b1;
    cyc_n(1);
    chk(32'(ovr), 32'h0);
    chk(cnt, 32'h0);
    // two events allowed in a 5 ms window, the third marks chatter
    wr(`SEOE_A_CHAT, 32'h00000502);
    for (i = 0; i < 4; i++)
      flip(7);
    chk(fault, 32'h80);
    cyc_n(150);
    chk(fault, 32'h0);
    // input 9 off->on capture disabled, 2 ms filter delays the level
    wr(`SEOE_A_CAPT, 32'hFFFFFDFF);
    wr(`SEOE_A_FILT, 32'h2);
    flip(9);
    chk(32'(lvl), 32'h000A);
    cyc_n(30);
    chk(32'(lvl), 32'h020A);
    chk(32'(pend), 32'h008A);
    final_report;
  end
endmodule
`default_nettype wire
